// file: sbc_irq_pkg.sv
// Constants of the interrupt control and status block
// Behaviour
// - Standby bit 0, Normal: CAN active, wake cleared
// - Standby bit 0, Standby/Sleep: CAN off, no wake
// - Standby bit 1: low-power, wake detect always on
// - Bit 2 picks 90 or 70 percent reset level
// - Sample bits: continuous, or synced to bias output
// - Bit 12 set makes the access read only
// - Bits 11, 10 flag supply undervoltage warnings
// - Bits 9, 8 flag LIN wake-ups
// - Bit 7 flags a pending cyclic interrupt
// - Bits 6, 4 flag local wake-pin wake-ups
// - Bit 5 power-on flag reads 1 after power-on
// - Bit 3 CAN wake flag, bits 2:0 read zero
// - Writing 1 clears the addressed flag
// - One oscillator clock times every internal timer
// - Edge select: off, rising, falling, both edges
// - Leaving Off mode sets the power-on flag
// - Watchdog timeout overflow sets the cyclic flag
`default_nettype none
package sbc_irq_pkg;
	// ==========================================
	// Frame layout
	localparam logic [4:0]  FRAME_BITS     = 5'h10;
	localparam logic [4:0]  ADDR_BITS      = 5'h03;
	localparam logic [2:0]  ADDR_CTRL      = 3'h2;
	localparam logic [2:0]  ADDR_STAT      = 3'h3;
	localparam int          B_LOCK         = 12;
	// ==========================================
	// Setup register fields
	localparam int          B_CORE_UV_EN   = 11;
	localparam int          B_CAN_UV_EN    = 10;
	localparam int          B_LIN_A_LP     = 9;
	localparam int          B_LIN_B_LP     = 8;
	localparam int          B_EDGE_A_LO    = 6;
	localparam int          B_EDGE_B_LO    = 4;
	localparam int          B_CAN_LP       = 3;
	localparam int          B_RESET_LVL    = 2;
	localparam int          B_SYNC_A       = 1;
	localparam int          B_SYNC_B       = 0;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_WMASK     = 16'h0fff;
	// ==========================================
	// Pending flag fields
	localparam int          B_CORE_LOW     = 11;
	localparam int          B_CAN_LOW      = 10;
	localparam int          B_LIN_A_WAKE   = 9;
	localparam int          B_LIN_B_WAKE   = 8;
	localparam int          B_CYCLIC       = 7;
	localparam int          B_WAKE_A       = 6;
	localparam int          B_POWER_UP     = 5;
	localparam int          B_WAKE_B       = 4;
	localparam int          B_CAN_WAKE     = 3;
	localparam logic [15:0] STAT_RESET     = 16'h0020;
	localparam logic [15:0] STAT_FLAG_MASK = 16'h0ff8;
endpackage
`default_nettype wire

// file: sbc_irq_ctrl.sv
// Interrupt setup, pending flags and serial register access
`timescale 1ns/1ps
`default_nettype none
module sbc_irq_ctrl (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Serial register port
	input  wire logic       spi_csn_n,
	input  wire logic       spi_sck,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	// Chip mode and events
	input  wire logic [1:0] sbc_mode_field,
	input  wire logic       core_supply_uv_evt,
	input  wire logic       can_supply_uv_evt,
	input  wire logic       lin_a_wake_evt,
	input  wire logic       lin_b_wake_evt,
	input  wire logic       can_bus_wake_evt,
	input  wire logic       wdg_timeout_overflow,
	input  wire logic       power_on_evt,
	// Wake pins
	input  wire logic       wake_pin_a,
	input  wire logic       wake_pin_b,
	input  wire logic       wake_bias_output,
	// Controls and status out
	output logic            can_active,
	output logic            can_wake_detect_en,
	output logic            can_receive_wake,
	output logic            reset_level_select,
	output logic            irq_output_low_n
);
	// ==========================================
	// Functions
	function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
		input logic cur);
		edge_hit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
	endfunction

	function automatic logic [15:0] flag_next(input logic [15:0] f,
		input logic [15:0] s, input logic [15:0] c);
		// A set in the clearing cycle wins
		flag_next = ((f & ~c) | s) & sbc_irq_pkg::STAT_FLAG_MASK;
	endfunction

	// ==========================================
	// Registers
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] stat_reg, stat_next;
	logic [15:0] rx_reg;
	logic [15:0] tx_reg;
	logic [4:0]  cnt_reg;
	logic        sck_reg;
	logic        csn_reg;
	logic        pin_a_reg, pin_b_reg;
	logic        can_xcvr_wake_reg;
	logic        irq_n_reg;
	logic        miso_reg;

	// ==========================================
	// Serial decode
	wire         sck_rise  = spi_sck & ~sck_reg & ~spi_csn_n;
	wire         sck_fall  = ~spi_sck & sck_reg & ~spi_csn_n;
	wire         frame_end = spi_csn_n & ~csn_reg;
	wire         frame_ok  = frame_end && cnt_reg == sbc_irq_pkg::FRAME_BITS;
	wire         do_write  = frame_ok & ~rx_reg[sbc_irq_pkg::B_LOCK];
	wire         wr_ctrl   = do_write && rx_reg[15:13] == sbc_irq_pkg::ADDR_CTRL;
	wire         wr_stat   = do_write && rx_reg[15:13] == sbc_irq_pkg::ADDR_STAT;
	wire [15:0]  rx_shift  = {rx_reg[14:0], spi_mosi};
	wire         addr_done = sck_rise && cnt_reg == sbc_irq_pkg::ADDR_BITS - 5'h01;
	wire [2:0]   rd_addr   = rx_shift[2:0];
	wire [15:0]  rd_word   = (rd_addr == sbc_irq_pkg::ADDR_CTRL) ?
		{rd_addr, 1'b0, ctrl_reg[11:0]} :
		(rd_addr == sbc_irq_pkg::ADDR_STAT) ? {rd_addr, 1'b0, stat_reg[11:0]} :
		{rd_addr, 13'h0000};

	// ==========================================
	// Mode decode
	wire         normal_mode = sbc_mode_field[1];
	wire         can_lp      = ctrl_reg[sbc_irq_pkg::B_CAN_LP];
	wire         can_detect  = can_lp;
	wire         can_run     = ~can_lp & normal_mode;

	// ==========================================
	// Wake pin sampling
	// Synced sampling saves bias current at the cost of slower detection
	wire         strobe_a = ~ctrl_reg[sbc_irq_pkg::B_SYNC_A] | wake_bias_output;
	wire         strobe_b = ~ctrl_reg[sbc_irq_pkg::B_SYNC_B] | wake_bias_output;
	wire         pin_a_cur = strobe_a ? wake_pin_a : pin_a_reg;
	wire         pin_b_cur = strobe_b ? wake_pin_b : pin_b_reg;
	wire         wake_a_hit = edge_hit(ctrl_reg[sbc_irq_pkg::B_EDGE_A_LO +: 2],
		pin_a_reg, pin_a_cur);
	wire         wake_b_hit = edge_hit(ctrl_reg[sbc_irq_pkg::B_EDGE_B_LO +: 2],
		pin_b_reg, pin_b_cur);

	// ==========================================
	// Flag sets and clears
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	always_comb begin
		flag_set = 16'h0000;
		flag_set[sbc_irq_pkg::B_CORE_LOW] = core_supply_uv_evt &
			ctrl_reg[sbc_irq_pkg::B_CORE_UV_EN];
		flag_set[sbc_irq_pkg::B_CAN_LOW] = can_supply_uv_evt &
			ctrl_reg[sbc_irq_pkg::B_CAN_UV_EN];
		flag_set[sbc_irq_pkg::B_LIN_A_WAKE] = lin_a_wake_evt &
			ctrl_reg[sbc_irq_pkg::B_LIN_A_LP];
		flag_set[sbc_irq_pkg::B_LIN_B_WAKE] = lin_b_wake_evt &
			ctrl_reg[sbc_irq_pkg::B_LIN_B_LP];
		flag_set[sbc_irq_pkg::B_CYCLIC] = wdg_timeout_overflow;
		flag_set[sbc_irq_pkg::B_WAKE_A] = wake_a_hit;
		flag_set[sbc_irq_pkg::B_POWER_UP] = power_on_evt;
		flag_set[sbc_irq_pkg::B_WAKE_B] = wake_b_hit;
		flag_set[sbc_irq_pkg::B_CAN_WAKE] = can_bus_wake_evt & can_detect;
		// Only ones clear; zeros leave flags alone
		flag_clr = wr_stat ? rx_reg : 16'h0000;
	end

	assign stat_next = flag_next(stat_reg, flag_set, flag_clr);
	assign ctrl_next = wr_ctrl ? (rx_reg & sbc_irq_pkg::CTRL_WMASK) : ctrl_reg;

	// ==========================================
	// Register state
	// Core clock is the battery-fed oscillator; no second time base
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_reg <= sbc_irq_pkg::CTRL_RESET;
			stat_reg <= sbc_irq_pkg::STAT_RESET;
			pin_a_reg <= 1'b0;
			pin_b_reg <= 1'b0;
			can_xcvr_wake_reg <= 1'b0;
			irq_n_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			stat_reg <= stat_next;
			pin_a_reg <= pin_a_cur;
			pin_b_reg <= pin_b_cur;
			can_xcvr_wake_reg <= ~can_run & (can_xcvr_wake_reg |
				(can_bus_wake_evt & can_detect));
			irq_n_reg <= ~|stat_next;
		end
	end

	// ==========================================
	// Serial shift state
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sck_reg <= 1'b0;
			csn_reg <= 1'b1;
			cnt_reg <= 5'h00;
			rx_reg <= 16'h0000;
			tx_reg <= 16'h0000;
			miso_reg <= 1'b0;
		end else begin
			sck_reg <= spi_sck;
			csn_reg <= spi_csn_n;
			if (spi_csn_n && !csn_reg) begin
				cnt_reg <= cnt_reg;
			end else if (!spi_csn_n && csn_reg) begin
				cnt_reg <= 5'h00;
			end else if (sck_rise && cnt_reg != 5'h1f) begin
				cnt_reg <= cnt_reg + 5'h01;
			end
			if (sck_rise) begin
				rx_reg <= rx_shift;
			end
			if (addr_done) begin
				tx_reg <= {rd_word[12:0], 3'h0};
			end else if (sck_fall) begin
				tx_reg <= {tx_reg[14:0], 1'b0};
			end
			if (sck_fall) begin
				miso_reg <= tx_reg[15];
			end
		end
	end

	// ==========================================
	// Outputs
	assign spi_miso = miso_reg;
	assign spi_miso_oe = ~spi_csn_n;
	assign can_active = can_run;
	assign can_wake_detect_en = can_detect;
	assign can_receive_wake = can_xcvr_wake_reg;
	assign reset_level_select = ctrl_reg[sbc_irq_pkg::B_RESET_LVL];
	assign irq_output_low_n = irq_n_reg;

	// ==========================================
	// Checks
	property p_can_run;
		@(posedge core_clk) disable iff (!resetn)
		(!ctrl_reg[3] && sbc_mode_field[1]) |-> can_active ##1 !can_receive_wake;
	endproperty
	a_can_run: assert property (p_can_run) else $error("CAN not active");

	property p_can_off;
		@(posedge core_clk) disable iff (!resetn)
		(!ctrl_reg[3] && !stat_reg[3]) |=> !stat_reg[3];
	endproperty
	a_can_off: assert property (p_can_off) else $error("CAN wake while off");

	property p_can_lp;
		@(posedge core_clk) disable iff (!resetn)
		(ctrl_reg[3] && can_bus_wake_evt) |=> (stat_reg[3] && !can_active);
	endproperty
	a_can_lp: assert property (p_can_lp) else $error("CAN wake missed");

	property p_lock;
		@(posedge core_clk) disable iff (!resetn)
		(frame_end && rx_reg[12]) |=> (ctrl_reg == $past(ctrl_reg));
	endproperty
	a_lock: assert property (p_lock) else $error("Locked write took effect");

	property p_clear;
		@(posedge core_clk) disable iff (!resetn)
		(wr_stat && rx_reg[9] && !lin_a_wake_evt) |=> !stat_reg[9];
	endproperty
	a_clear: assert property (p_clear) else $error("Flag not cleared");

	property p_keep;
		@(posedge core_clk) disable iff (!resetn)
		(stat_reg[7] && !(wr_stat && rx_reg[7])) |=> stat_reg[7];
	endproperty
	a_keep: assert property (p_keep) else $error("Flag lost");

	property p_cyclic;
		@(posedge core_clk) disable iff (!resetn)
		wdg_timeout_overflow |=> stat_reg[7];
	endproperty
	a_cyclic: assert property (p_cyclic) else $error("Cyclic flag not set");

	property p_power;
		@(posedge core_clk) disable iff (!resetn)
		power_on_evt |=> stat_reg[5] ##1 !irq_output_low_n;
	endproperty
	a_power: assert property (p_power) else $error("Power-up flag missing");

	property p_irq;
		@(posedge core_clk) disable iff (!resetn)
		(stat_reg == 16'h0000) |=> $stable(stat_reg) |-> irq_output_low_n;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt line stuck");

	property p_resv;
		@(posedge core_clk) disable iff (!resetn)
		stat_reg[2:0] == 3'h0 && stat_reg[15:12] == 4'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("Reserved bits set");

	property p_irq_track;
		@(posedge core_clk) disable iff (!resetn)
		irq_output_low_n == (stat_reg == 16'h0000);
	endproperty
	a_irq_track: assert property (p_irq_track) else $error("Irq mismatch");

	property p_can_standby;
		@(posedge core_clk) disable iff (!resetn)
		(!ctrl_reg[sbc_irq_pkg::B_CAN_LP] && !sbc_mode_field[1]) |->
			(!can_active && !can_wake_detect_en);
	endproperty
	a_can_standby: assert property (p_can_standby) else $error("CAN not off");

	property p_reset_lvl;
		@(posedge core_clk) disable iff (!resetn)
		wr_ctrl |=> (reset_level_select == $past(rx_reg[sbc_irq_pkg::B_RESET_LVL]));
	endproperty
	a_reset_lvl: assert property (p_reset_lvl) else $error("Reset level wrong");

	property p_lock_stat;
		@(posedge core_clk) disable iff (!resetn)
		(frame_end && rx_reg[sbc_irq_pkg::B_LOCK] &&
			stat_reg[sbc_irq_pkg::B_POWER_UP]) |=> stat_reg[sbc_irq_pkg::B_POWER_UP];
	endproperty
	a_lock_stat: assert property (p_lock_stat) else $error("Lock ignored");

	property p_uv_set;
		@(posedge core_clk) disable iff (!resetn)
		(core_supply_uv_evt && ctrl_reg[sbc_irq_pkg::B_CORE_UV_EN]) |=>
			stat_reg[sbc_irq_pkg::B_CORE_LOW];
	endproperty
	a_uv_set: assert property (p_uv_set) else $error("UV flag missed");

	property p_lin_gate;
		@(posedge core_clk) disable iff (!resetn)
		(!ctrl_reg[sbc_irq_pkg::B_LIN_A_LP] &&
			!stat_reg[sbc_irq_pkg::B_LIN_A_WAKE]) |=> !stat_reg[sbc_irq_pkg::B_LIN_A_WAKE];
	endproperty
	a_lin_gate: assert property (p_lin_gate) else $error("LIN flag while off");

	// Held samples keep a pin edge pending until the bias strobe comes
	property p_wake_hold;
		@(posedge core_clk) disable iff (!resetn)
		(ctrl_reg[sbc_irq_pkg::B_SYNC_A] && !wake_bias_output) |=> $stable(pin_a_reg);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("Sample not held");

	property p_wake_a_fall;
		@(posedge core_clk) disable iff (!resetn)
		(ctrl_reg[sbc_irq_pkg::B_EDGE_A_LO + 1] &&
			!ctrl_reg[sbc_irq_pkg::B_SYNC_A] && !wake_pin_a && pin_a_reg) |=>
			stat_reg[sbc_irq_pkg::B_WAKE_A];
	endproperty
	a_wake_a_fall: assert property (p_wake_a_fall) else $error("Fall missed");

	property p_wake_b_rise;
		@(posedge core_clk) disable iff (!resetn)
		(ctrl_reg[sbc_irq_pkg::B_EDGE_B_LO] && wake_bias_output &&
			wake_pin_b && !pin_b_reg) |=> stat_reg[sbc_irq_pkg::B_WAKE_B];
	endproperty
	a_wake_b_rise: assert property (p_wake_b_rise) else $error("Rise missed");
endmodule // sbc_irq_ctrl
`default_nettype wire

// file: sbc_irq_host.sv
// Host serial master model for the interrupt block
`timescale 1ns/1ps
`default_nettype none
module sbc_irq_host (
	// Clock
	input  wire logic core_clk,
	// Serial port
	output logic      spi_csn_n,
	output logic      spi_sck,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	// ==========
	// Frames
	initial begin
		spi_csn_n = 1'b1;
		spi_sck   = 1'b0;
		spi_mosi  = 1'b0;
	end
	// Sends n bits of f MSB first; n other than 16 tests refusal
	task automatic xfer(input logic [16:0] f, input int n, output logic [16:0] rx);
		rx = 17'h00000;
		@(posedge core_clk);
		spi_csn_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			spi_sck  <= 1'b0;
			spi_mosi <= f[i];
			repeat (3) @(posedge core_clk);
			spi_sck <= 1'b1;
			rx[i] = spi_miso;
			repeat (2) @(posedge core_clk);
		end
		spi_sck   <= 1'b0;
		// Released data line must not keep the last bit
		spi_mosi  <= ~spi_mosi;
		repeat (2) @(posedge core_clk);
		spi_csn_n <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [11:0] d, input logic lock);
		logic [16:0] r;
		xfer({1'b0, a, lock, d}, 16, r);
	endtask
	// Reads go out locked so they can never clear a flag
	task automatic rd(input logic [2:0] a, output logic [15:0] q);
		logic [16:0] r;
		xfer({1'b0, a, 1'b1, 12'h000}, 16, r);
		q = {3'h0, r[12:0]};
	endtask
endmodule // sbc_irq_host
`default_nettype wire

// file: tb_sbc_interrupt_status_ctrl.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
`default_nettype none
module tb_sbc_interrupt_status_ctrl;
	logic        core_clk, resetn, spi_csn_n, spi_sck, spi_mosi, spi_miso;
	logic [1:0]  sbc_mode_field, m;
	logic [6:0]  ev;
	logic        wake_pin_a, wake_pin_b, wake_bias_output, rw;
	logic        can_active, can_wake_detect_en, can_receive_wake;
	logic        reset_level_select, irq_output_low_n, miso_oe;
	logic [15:0] q, c, e;
	logic [16:0] r;
	int          mismatches = 0;
	int          checked = 0;
	int          cyc = 0;
	sbc_irq_host i_sbc_irq_host (.core_clk(core_clk), .spi_csn_n(spi_csn_n),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
	sbc_irq_ctrl i_sbc_irq_ctrl (.core_clk(core_clk), .resetn(resetn),
		.spi_csn_n(spi_csn_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(miso_oe), .sbc_mode_field(sbc_mode_field),
		.core_supply_uv_evt(ev[6]), .can_supply_uv_evt(ev[5]), .lin_a_wake_evt(ev[4]),
		.lin_b_wake_evt(ev[3]), .wdg_timeout_overflow(ev[2]), .power_on_evt(ev[1]),
		.can_bus_wake_evt(ev[0]), .wake_pin_a(wake_pin_a), .wake_pin_b(wake_pin_b),
		.wake_bias_output(wake_bias_output), .can_active(can_active),
		.can_wake_detect_en(can_wake_detect_en), .can_receive_wake(can_receive_wake),
		.reset_level_select(reset_level_select), .irq_output_low_n(irq_output_low_n));
	// ==========
	// Checking
	function automatic logic [15:0] flags(input logic [15:0] x, input logic [6:0] v);
		return {4'h0, v[6] & x[11], v[5] & x[10], v[4] & x[9], v[3] & x[8], v[2],
			1'b0, v[1], 1'b0, v[0] & x[3], 3'h0};
	endfunction
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic results;
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Generous ceiling over some 24000 cycles of frames
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			mismatches++;
			results();
		end
	end
	// Data line is driven only inside a frame
	always @(posedge core_clk) begin
		if (resetn) begin
			chk("miso oe", {15'h0, ~spi_csn_n}, {15'h0, miso_oe});
		end
	end
	// ==========
	// Scenarios
	initial begin
		{resetn, sbc_mode_field, ev, wake_pin_a, wake_pin_b, rw} = '0;
		wake_bias_output = 1'b1;
		void'($urandom(32'hae49a376));
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		i_sbc_irq_host.rd(3'h3, q);
		chk("status reset", 16'h0020, q);
		chk("irq reset", 16'h0000, {15'h0, irq_output_low_n});
		i_sbc_irq_host.rd(3'h2, q);
		chk("setup reset", 16'h0000, q);
		i_sbc_irq_host.wr(3'h3, 12'h020, 1'b1);
		// Short and long frames whose last 16 bits would clear the power-up flag
		i_sbc_irq_host.xfer(17'h06020, 15, r);
		i_sbc_irq_host.xfer(17'h06020, 17, r);
		i_sbc_irq_host.rd(3'h3, q);
		chk("refused", 16'h0020, q);
		i_sbc_irq_host.wr(3'h3, 12'h020, 1'b0);
		i_sbc_irq_host.rd(3'h3, q);
		chk("power clear", 16'h0000, q);
		chk("irq free", 16'h0001, {15'h0, irq_output_low_n});
		for (int k = 0; k < 40; k++) begin
			c = {4'h0, 12'($urandom())};
			i_sbc_irq_host.wr(3'h2, c[11:0], 1'b0);
			m = sbc_mode_field;
			sbc_mode_field <= 2'($urandom());
			@(posedge core_clk);
			ev <= 7'($urandom());
			@(posedge core_clk);
			e = flags(c, ev);
			ev <= 7'h00;
			rw = c[3] ? (rw | ev[0]) : ((m[1] | sbc_mode_field[1]) ? 1'b0 : rw);
			i_sbc_irq_host.rd(3'h3, q);
			chk("flags", e, q);
			chk("irq", {15'h0, e == 16'h0}, {15'h0, irq_output_low_n});
			chk("can on", {15'h0, ~c[3] & sbc_mode_field[1]}, {15'h0, can_active});
			chk("ctl", {13'h0, c[3:2], rw}, {13'h0, can_wake_detect_en,
				reset_level_select, can_receive_wake});
			i_sbc_irq_host.wr(3'h3, 12'h000, 1'b0);
			i_sbc_irq_host.rd(3'h3, q);
			chk("write zero", e, q);
			i_sbc_irq_host.wr(3'h3, 12'hff8, 1'b0);
			i_sbc_irq_host.rd(3'h3, q);
			chk("clear", 16'h0000, q);
		end
		for (int s = 0; s < 4; s++) begin
			i_sbc_irq_host.wr(3'h2, {4'h0, 2'(s), 2'(s), 4'h3}, 1'b0);
			for (int l = 1; l >= 0; l--) begin
				wake_pin_a <= l[0];
				wake_pin_b <= l[0];
				repeat (4) @(posedge core_clk);
				i_sbc_irq_host.rd(3'h3, q);
				chk("edge", {9'h0, s[1 - l], 1'b0, s[1 - l], 4'h0}, q);
				i_sbc_irq_host.wr(3'h3, 12'h050, 1'b0);
			end
		end
		// Sync sampling with the strobe low must hold off the edge until the strobe
		wake_bias_output <= 1'b0;
		wake_pin_a <= 1'b1;
		repeat (4) @(posedge core_clk);
		i_sbc_irq_host.rd(3'h3, q);
		chk("sync hold", 16'h0000, q);
		wake_bias_output <= 1'b1;
		repeat (4) @(posedge core_clk);
		i_sbc_irq_host.rd(3'h3, q);
		chk("sync take", 16'h0040, q);
		i_sbc_irq_host.wr(3'h3, 12'h050, 1'b0);
		// Continuous sampling sees the pin even with the strobe low
		wake_bias_output <= 1'b0;
		i_sbc_irq_host.wr(3'h2, 12'h0f0, 1'b0);
		wake_pin_a <= 1'b0;
		repeat (4) @(posedge core_clk);
		i_sbc_irq_host.rd(3'h3, q);
		chk("continuous", 16'h0040, q);
		results();
	end
endmodule // tb_sbc_interrupt_status_ctrl
`default_nettype wire
